// >>> common/ipd_map.vh
`ifndef IPD_MAP_VH
`define IPD_MAP_VH
// Word count and index width
`define IPD_WORDS 256
`define IPD_IDXW 8
// Command opcodes
`define IPD_OP_IDENT 8'hA1
`define IPD_OP_IDLE 8'hE3
// Word indices
`define IPD_W_CFG 8'd0
`define IPD_W_SPEC 8'd2
`define IPD_W_SER_LO 8'd10
`define IPD_W_SER_HI 8'd19
`define IPD_W_FW_LO 8'd23
`define IPD_W_MOD_HI 8'd46
`define IPD_W_CAP 8'd49
`define IPD_W_VALID 8'd53
`define IPD_W_DMA_LO 8'd63
`define IPD_W_PIO_HI 8'd68
`define IPD_W_PKT_REL 8'd71
`define IPD_W_SVC_REL 8'd72
`define IPD_W_QDEPTH 8'd75
`define IPD_W_REV_LO 8'd80
`define IPD_W_REV_HI 8'd90
`define IPD_W_HRST 8'd93
`define IPD_W_RMSN 8'd127
`define IPD_W_SEC 8'd128
`define IPD_W_INTEG 8'd255
// Word 0 encodings
`define IPD_TYPE_ATA 2'b00
`define IPD_TYPE_PKT 2'b10
`define IPD_DRQ_3MS 2'b00
`define IPD_DRQ_50US 2'b10
`define IPD_DRQ_RSV 2'b11
`define IPD_PKT_12 2'b00
`define IPD_PKT_16 2'b01
`define IPD_PTYPE_RSV_LO 5'h10
`define IPD_PTYPE_UNKNOWN 5'h1F
// Word 49 bit positions
`define IPD_CAP_IDMA 15
`define IPD_CAP_QUEUE 14
`define IPD_CAP_OVL 13
`define IPD_CAP_IORDY 11
`define IPD_CAP_IORDY_DIS 10
`define IPD_CAP_LBA 9
`define IPD_CAP_DMA 8
// Status bits
`define IPD_ST_BSY 7
`define IPD_ST_DRDY 6
`define IPD_ST_DRQ 3
`define IPD_ST_ERR 0
`define IPD_ER_ABRT 2
`endif

// >>> hw/ipd_word_mux.v
`timescale 1ns/1ps
`include "ipd_map.vh"
module ipd_word_mux (
  // Selected word
  input wire [7:0] idx,
  // Composed and mirrored words
  input wire [15:0] cfg_word,
  input wire [15:0] cap_word,
  input wire [15:0] pkt_rel,
  input wire [15:0] svc_rel,
  input wire [4:0] qdepth,
  input wire ser_en,
  input wire [15:0] mirror_word,
  // Result
  output reg [15:0] word
);
  // -------------------------
  // Word selection by index
  // -------------------------
  function is_mirror;
    input [7:0] i;
    begin
      is_mirror = (i == `IPD_W_SPEC) || (i >= `IPD_W_FW_LO && i <= `IPD_W_MOD_HI) ||
        (i == `IPD_W_VALID) || (i >= `IPD_W_DMA_LO && i <= `IPD_W_PIO_HI) ||
        (i >= `IPD_W_REV_LO && i <= `IPD_W_REV_HI) || (i == `IPD_W_HRST) ||
        (i == `IPD_W_RMSN) || (i == `IPD_W_SEC) || (i == `IPD_W_INTEG);
    end
  endfunction
  always @* begin
    word = 16'h0000; // Reserved words read zero
    if (idx == `IPD_W_CFG) begin
      word = cfg_word;
    end else if (idx == `IPD_W_CAP) begin
      word = cap_word;
    end else if (idx == `IPD_W_PKT_REL) begin
      word = pkt_rel;
    end else if (idx == `IPD_W_SVC_REL) begin
      word = svc_rel;
    end else if (idx == `IPD_W_QDEPTH) begin
      word = {11'h000, qdepth};
    end else if (idx >= `IPD_W_SER_LO && idx <= `IPD_W_SER_HI) begin
      word = ser_en ? mirror_word : 16'h0000;
    end else if (is_mirror(idx)) begin
      word = mirror_word;
    end
  end
endmodule

// >>> hw/ipd_top.v
`timescale 1ns/1ps
`include "ipd_map.vh"
module ipd_top #(
  parameter [15:0] PKT_REL_US = 16'h0000,
  parameter [15:0] SVC_REL_US = 16'h0000
) (
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Command strobe from the task file logic
  input wire CMD_STB,
  input wire [7:0] CMD_OP,
  // Configuration straps
  input wire PKT_SET,
  input wire [4:0] PERIPH_TYPE,
  input wire REMOVABLE,
  input wire FAST_DRQ,
  input wire PKT16,
  input wire SER_EN,
  input wire PWR_MGMT,
  input wire CAP_IDMA,
  input wire CAP_QUEUE,
  input wire CAP_OVL,
  input wire PIO3_UP,
  input wire IORDY_SUP,
  input wire IORDY_DIS,
  input wire CAP_LBA,
  input wire CAP_DMA,
  input wire [4:0] QDEPTH,
  // Mirrored word source, combinational lookup by index
  output reg [7:0] MIRROR_IDX,
  input wire [15:0] MIRROR_WORD,
  // Data-in port
  output reg [15:0] DATA_OUT,
  output reg DATA_VALID,
  input wire DATA_TAKE,
  // Status
  output reg BUSY,
  output reg DRQ,
  output reg ERR,
  output reg ABORTED,
  output reg DONE,
  output reg IDLE_MODE
);
  // -------------------------
  // State machine
  // -------------------------
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_LOAD = 3'b010;
  localparam [2:0] S_SEND = 3'b100;
  // Sequencer state and word index
  reg [2:0] state;
  reg [7:0] idx;
  reg last;
  wire [15:0] cfg_word;
  wire [15:0] cap_word;
  wire [15:0] word;
  // Composed fields of word 0 and word 49
  reg [4:0] ptype;
  reg [1:0] dtype;
  reg [1:0] drq_code;
  reg [1:0] pkt_code;
  reg queue_ok;
  reg iordy_ok;
  // Next values of the sequencer and the outputs
  reg [2:0] next_state;
  reg [7:0] next_idx;
  reg next_last;
  reg [15:0] next_data_out;
  reg next_data_valid;
  reg next_busy;
  reg next_drq;
  reg next_done;
  reg next_err;
  reg next_aborted;
  reg next_idle_mode;
  // Decoded command strobes
  wire idle_cmd;
  wire ident_cmd;
  // Strap snapshot, frozen for the length of one block
  reg snap_pkt;
  reg [4:0] snap_ptype;
  reg snap_rmv;
  reg snap_fast_drq;
  reg snap_pkt16;
  reg snap_ser;
  reg [7:0] snap_cap;
  reg [4:0] snap_qdepth;

  // -------------------------
  // Command decode
  // -------------------------
  // Opcode match qualified by the strobe
  function cmd_hit;
    input stb;
    input [7:0] op;
    input [7:0] code;
    begin
      cmd_hit = stb && (op == code);
    end
  endfunction
  assign idle_cmd = cmd_hit(CMD_STB, CMD_OP, `IPD_OP_IDLE);
  assign ident_cmd = cmd_hit(CMD_STB, CMD_OP, `IPD_OP_IDENT);

  // -------------------------
  // Strap snapshot
  // -------------------------
  // Straps are sampled when an identify command is taken, so a strap
  // that moves mid-block cannot tear word 0 from word 49
  always @(posedge MCLK) begin
    if (RST) begin
      snap_pkt <= 1'b0;
      snap_ptype <= 5'h00;
      snap_rmv <= 1'b0;
      snap_fast_drq <= 1'b0;
      snap_pkt16 <= 1'b0;
      snap_ser <= 1'b0;
      snap_cap <= 8'h00;
      snap_qdepth <= 5'h00;
    end else if (state == S_IDLE && ident_cmd) begin
      snap_pkt <= PKT_SET;
      snap_ptype <= PERIPH_TYPE;
      snap_rmv <= REMOVABLE;
      snap_fast_drq <= FAST_DRQ;
      snap_pkt16 <= PKT16;
      snap_ser <= SER_EN;
      snap_cap <= {CAP_IDMA, CAP_QUEUE, CAP_OVL, PIO3_UP, IORDY_SUP, IORDY_DIS, CAP_LBA, CAP_DMA};
      snap_qdepth <= QDEPTH;
    end
  end

  // -------------------------
  // Word 0 and word 49 composition
  // -------------------------
  always @* begin
    dtype = snap_pkt ? `IPD_TYPE_PKT : `IPD_TYPE_ATA; // Never 11
    ptype = (snap_ptype >= `IPD_PTYPE_RSV_LO && snap_ptype != `IPD_PTYPE_UNKNOWN) ?
      `IPD_PTYPE_UNKNOWN : snap_ptype; // Reserved codes become unknown
    drq_code = snap_fast_drq ? `IPD_DRQ_50US : `IPD_DRQ_3MS;
    pkt_code = snap_pkt16 ? `IPD_PKT_16 : `IPD_PKT_12;
    queue_ok = snap_cap[6] & snap_cap[5];
    iordy_ok = snap_cap[3] | snap_cap[4];
  end
  assign cfg_word = {dtype, 1'b0, ptype, snap_rmv, drq_code, 3'b000, pkt_code};
  assign cap_word = {snap_cap[7], queue_ok, snap_cap[5], 1'b0, iordy_ok, snap_cap[2:0],
    8'h00};

  ipd_word_mux u_mux (
    .idx(idx),
    .cfg_word(cfg_word),
    .cap_word(cap_word),
    .pkt_rel(PKT_REL_US),
    .svc_rel(SVC_REL_US),
    .qdepth(snap_qdepth),
    .ser_en(snap_ser),
    .mirror_word(MIRROR_WORD),
    .word(word)
  );

  // -------------------------
  // Command handling and data-in phase
  // -------------------------
  // Next values of the sequencer and the outputs
  always @* begin
    // Everything except DONE holds unless a state says otherwise; DONE defaults to zero
    next_state = state;
    next_idx = idx;
    next_last = last;
    next_data_out = DATA_OUT;
    next_data_valid = DATA_VALID;
    next_busy = BUSY;
    next_drq = DRQ;
    next_done = 1'b0;
    next_err = ERR;
    next_aborted = ABORTED;
    next_idle_mode = IDLE_MODE;
    case (state)
      S_IDLE: begin
        if (idle_cmd) begin
          // Non-data completion, no DRQ
          next_err = ~PWR_MGMT;
          next_aborted = ~PWR_MGMT;
          next_idle_mode = PWR_MGMT;
          next_done = 1'b1;
        end else if (ident_cmd) begin
          next_err = 1'b0;
          next_aborted = 1'b0;
          next_busy = 1'b1;
          next_idx = 8'h00;
          next_last = 1'b0;
          next_state = S_LOAD;
        end
      end
      S_LOAD: begin
        // Word is offered while DRQ stands
        next_data_out = word;
        next_data_valid = 1'b1;
        next_drq = 1'b1;
        next_busy = 1'b0;
        // Flags the final word so its take ends the block
        next_last = (idx == `IPD_W_INTEG);
        next_state = S_SEND;
      end
      S_SEND: begin
        if (DATA_TAKE) begin
          // Host has taken the word
          next_data_valid = 1'b0;
          if (last) begin
            next_drq = 1'b0;
            next_done = 1'b1;
            next_state = S_IDLE;
          end else begin
            next_idx = idx + 8'h01; // Ascending word order
            next_state = S_LOAD;
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // -------------------------
  // Sequencer registers
  // -------------------------
  // State, word index and the index shown to the mirror source
  always @(posedge MCLK) begin
    if (RST) begin
      state <= S_IDLE;
      idx <= 8'h00;
      last <= 1'b0;
      MIRROR_IDX <= 8'h00;
    end else begin
      state <= next_state;
      idx <= next_idx;
      last <= next_last;
      MIRROR_IDX <= next_idx;
    end
  end

  // -------------------------
  // Data-in port registers
  // -------------------------
  // Word and its valid flag, held until taken
  always @(posedge MCLK) begin
    if (RST) begin
      DATA_OUT <= 16'h0000;
      DATA_VALID <= 1'b0;
    end else begin
      DATA_OUT <= next_data_out;
      DATA_VALID <= next_data_valid;
    end
  end

  // -------------------------
  // Status registers
  // -------------------------
  // Handshake flags of the transfer
  always @(posedge MCLK) begin
    if (RST) begin
      BUSY <= 1'b0;
      DRQ <= 1'b0;
      DONE <= 1'b0;
    end else begin
      BUSY <= next_busy;
      DRQ <= next_drq;
      DONE <= next_done;
    end
  end

  // -------------------------
  // Command result registers
  // -------------------------
  // Result flags; ERR and ABORTED held until the next command, IDLE_MODE until the next idle command
  always @(posedge MCLK) begin
    if (RST) begin
      ERR <= 1'b0;
      ABORTED <= 1'b0;
      IDLE_MODE <= 1'b0;
    end else begin
      ERR <= next_err;
      ABORTED <= next_aborted;
      IDLE_MODE <= next_idle_mode;
    end
  end
endmodule

// >>> verification/ipd_monitor.sv
`timescale 1ns/1ps
module ipd_monitor (
  // Observed top-level ports
  input wire MCLK, input wire RST, input wire CMD_STB, input wire [7:0] CMD_OP,
  input wire PKT_SET, input wire PWR_MGMT, input wire [15:0] DATA_OUT, input wire DATA_VALID,
  input wire DATA_TAKE, input wire BUSY, input wire DRQ, input wire ERR, input wire ABORTED,
  input wire DONE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  reg [7:0] taken;
  reg drq_d;
  wire tk = DATA_VALID && DATA_TAKE;
  wire rdy = !BUSY && !DRQ && !drq_d && !DATA_VALID && !DONE;
  // Words taken, wraps once per block
  always @(posedge MCLK) begin
    taken <= RST ? 8'h00 : taken + {7'h00, tk};
    drq_d <= DRQ;
  end
  a_idle_flags: assert property (CMD_STB && CMD_OP == 8'hE3 && rdy |=>
    DONE && ERR == !$past(PWR_MGMT) && ABORTED == ERR)
    else $error("idle flags");
  a_ident_start: assert property (CMD_STB && CMD_OP == 8'hA1 && rdy |=>
    BUSY ##1 DATA_VALID && DRQ && taken == 8'h00)
    else $error("ident start");
  a_word_holds: assert property (DATA_VALID && !DATA_TAKE |=> DATA_VALID && $stable(DATA_OUT))
    else $error("word dropped");
  a_next_word: assert property (tk && taken != 8'hFF |=> !DATA_VALID ##1 DATA_VALID)
    else $error("next word");
  a_last_done: assert property (tk && taken == 8'hFF |=> ##[0:1] DONE)
    else $error("no done");
  a_word0_type: assert property (DATA_VALID && taken == 8'h00 |-> DATA_OUT[15:14] == {PKT_SET, 1'b0})
    else $error("device type");
  a_queue_ovl: assert property (DATA_VALID && taken == 8'd49 |-> !DATA_OUT[14] || DATA_OUT[13])
    else $error("queue bit");
  a_rsvd_zero: assert property (DATA_VALID && (taken == 8'd1 || taken > 8'd128 && taken < 8'd255) |->
    DATA_OUT == 16'h0000)
    else $error("reserved word");
endmodule
bind ipd_top ipd_monitor ipd_monitor_i(.MCLK, .RST, .CMD_STB, .CMD_OP, .PKT_SET, .PWR_MGMT, .DATA_OUT,
  .DATA_VALID, .DATA_TAKE, .BUSY, .DRQ, .ERR, .ABORTED, .DONE);

// >>> verification/ipd_host_model.sv
`timescale 1ns/1ps
module ipd_host_model (
  // Clock and data-in port
  input wire MCLK,
  input wire DATA_VALID,
  input wire [15:0] DATA_OUT,
  output reg DATA_TAKE
);
  reg [15:0] words [0:255];
  integer cnt = 0;
  integer stall = 0;
  integer w = 0;
  initial DATA_TAKE = 1'b0;
  // Capture at the taking edge, then pace the next take
  always @(posedge MCLK) begin
    if (DATA_TAKE && DATA_VALID) begin
      words[cnt % 256] = DATA_OUT;
      cnt = cnt + 1;
    end
    #1;
    if (DATA_TAKE) begin
      DATA_TAKE = 1'b0;
      w = 0;
    end else if (DATA_VALID) begin
      if (w >= stall) DATA_TAKE = 1'b1;
      w = w + 1;
    end
  end
endmodule

// >>> verification/ipd_top_tb.sv
`timescale 1ns/1ps
module ipd_top_tb;
  reg MCLK = 0, RST = 1, CMD_STB = 0, PWR_MGMT = 0;
  reg [7:0] CMD_OP = 8'h00;
  reg PKT_SET, REMOVABLE, FAST_DRQ, PKT16, SER_EN, CAP_IDMA, CAP_QUEUE, CAP_OVL;
  reg PIO3_UP, IORDY_SUP, IORDY_DIS, CAP_LBA, CAP_DMA;
  reg [4:0] PERIPH_TYPE, QDEPTH;
  wire [7:0] MIRROR_IDX;
  wire [15:0] DATA_OUT;
  wire DATA_VALID, DATA_TAKE, BUSY, DRQ, ERR, ABORTED, DONE, IDLE_MODE;
  wire [15:0] MIRROR_WORD = {~MIRROR_IDX, MIRROR_IDX};
  integer err_count = 0, total_checks = 0, cyc = 0;
  localparam [15:0] PREL = 16'h0032, SREL = 16'h0064;
  always #5 MCLK = ~MCLK;
  ipd_top #(.PKT_REL_US(PREL), .SVC_REL_US(SREL)) ipd_top_i(.MCLK, .RST, .CMD_STB, .CMD_OP, .PKT_SET,
    .PERIPH_TYPE, .REMOVABLE, .FAST_DRQ, .PKT16, .SER_EN, .PWR_MGMT, .CAP_IDMA, .CAP_QUEUE, .CAP_OVL,
    .PIO3_UP, .IORDY_SUP, .IORDY_DIS, .CAP_LBA, .CAP_DMA, .QDEPTH, .MIRROR_IDX, .MIRROR_WORD, .DATA_OUT,
    .DATA_VALID, .DATA_TAKE, .BUSY, .DRQ, .ERR, .ABORTED, .DONE, .IDLE_MODE);
  ipd_host_model ipd_host_model_i(.MCLK, .DATA_VALID, .DATA_OUT, .DATA_TAKE);
  // Expected word by index
  function [15:0] ex(input [7:0] i);
    reg [4:0] p;
    reg [15:0] m;
    begin
      p = (PERIPH_TYPE > 5'h0F && PERIPH_TYPE < 5'h1F) ? 5'h1F : PERIPH_TYPE;
      m = {~i, i};
      case (i)
        0: ex = {PKT_SET, 2'b00, p, REMOVABLE, FAST_DRQ, 5'h00, PKT16};
        49: ex = {CAP_IDMA, CAP_QUEUE & CAP_OVL, CAP_OVL, 1'b0,
          IORDY_SUP | PIO3_UP, IORDY_DIS, CAP_LBA, CAP_DMA, 8'h00};
        71: ex = PREL;
        72: ex = SREL;
        75: ex = {11'h000, QDEPTH};
        2, 53, 93, 127, 128, 255: ex = m;
        default: ex = (i > 22 && i < 47 || i > 62 && i < 69 || i > 79 && i < 91 ||
          SER_EN && i > 9 && i < 20) ? m : 16'h0000;
      endcase
    end
  endfunction
  task chk(input string n, input [15:0] g, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task st(input [12:0] f, input [4:0] p, input [4:0] q);
    begin
      {PKT_SET, REMOVABLE, FAST_DRQ, PKT16, SER_EN, CAP_IDMA, CAP_QUEUE, CAP_OVL, PIO3_UP, IORDY_SUP, IORDY_DIS,
        CAP_LBA, CAP_DMA} = f;
      PERIPH_TYPE = p;
      QDEPTH = q;
    end
  endtask
  task op(input [7:0] c);
    begin
      CMD_OP = c;
      CMD_STB = 1'b1;
      @(posedge MCLK);
      #1 CMD_STB = 1'b0;
    end
  endtask
  // Full identify block through a paced host
  task ident(input integer s);
    integer k;
    begin
      ipd_host_model_i.stall = s;
      ipd_host_model_i.cnt = 0;
      op(8'hA1);
      k = 0;
      while (DONE !== 1'b1 && k < 3000) begin
        @(posedge MCLK);
        #1 k = k + 1;
      end
      chk("count", ipd_host_model_i.cnt, 16'h0100);
      chk("cfg", ipd_host_model_i.words[0], ex(8'h00));
      chk("cap", ipd_host_model_i.words[49], ex(8'h31));
      for (k = 0; k < 256; k = k + 1) begin
        chk("word", ipd_host_model_i.words[k], ex(k));
      end
    end
  endtask
  // Idle command with and without power management
  task idle(input pm);
    begin
      PWR_MGMT = pm;
      op(8'hE3);
      chk("done", DONE, 1);
      chk("err", ERR, !pm);
      chk("abort", ABORTED, !pm);
      chk("mode", IDLE_MODE, pm);
      @(posedge MCLK);
      #1;
    end
  endtask
  // Cycle ceiling
  always @(posedge MCLK) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  initial begin
    st(13'h1FEF, 5'h05, 5'h1F);
    repeat (10) @(posedge MCLK);
    #1 RST = 1'b0;
    ident(0);
    st(13'h0050, 5'h12, 5'h03);
    ident(3);
    idle(1'b0);
    idle(1'b1);
    tally_and_finish;
  end
endmodule
